//--- pkg/charger_pkg.sv
// Charger state machine package: states, timeout codes, timing counts.
// Assumes a 125 MHz system clock; timer ticks are derived from it.
package charger_pkg;

  typedef enum logic [2:0] {
    ST_SUSPEND  = 3'b000,
    ST_PRECOND  = 3'b001,
    ST_FAST     = 3'b010,
    ST_TOPOFF   = 3'b011,
    ST_SLEEP    = 3'b100,
    ST_FAULT    = 3'b101,
    ST_NOBAT    = 3'b110
  } charge_state_t;

  // Timeout select codes
  localparam logic [1:0] TMO_1H       = 2'h0;
  localparam logic [1:0] TMO_1P43H    = 2'h1;
  localparam logic [1:0] TMO_2H       = 2'h2;
  localparam logic [1:0] TMO_OFF      = 2'h3;
  localparam logic [1:0] TIMEOUT_SELECT_RESET = 2'h0;

  // Clock and tick: one tick per 36 s (0.01 hour); the count needs more than 32 bits
  localparam int unsigned     CLK_HZ       = 125000000;
  localparam int unsigned     TICK_SECONDS = 36;
  localparam longint unsigned TICK_CYCLES  = longint'(CLK_HZ) * TICK_SECONDS;

  // Timeouts in hundredths of an hour, as ticks
  localparam logic [9:0] PRE_TICKS_1H    = 10'h064;
  localparam logic [9:0] PRE_TICKS_1P43H = 10'h08F;
  localparam logic [9:0] PRE_TICKS_2H    = 10'h0C8;
  localparam logic [9:0] TOT_TICKS_3H    = 10'h12C;
  localparam logic [9:0] TOT_TICKS_4P3H  = 10'h1AE;
  localparam logic [9:0] TOT_TICKS_6H    = 10'h258;

  // Current limit code for the battery-less mode: 1000 mA
  localparam logic [3:0] NOBAT_CURRENT_CODE = 4'hF;

endpackage : charger_pkg

//--- pkg/timer_if.sv
// Interface between the state machine and its safety timer.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface timer_if;
  logic       clear;      // Restart both counts
  logic       run_pre;    // Count precondition time
  logic       run_tot;    // Count total time
  logic [1:0] select;     // Timeout selection
  logic       pre_done;   // Precondition time expired
  logic       tot_done;   // Total time expired
  modport ctrl  (output clear, run_pre, run_tot, select, input pre_done, tot_done);
  modport timer (input clear, run_pre, run_tot, select, output pre_done, tot_done);
endinterface : timer_if
`default_nettype wire

//--- src/charge_timer.sv
// Precondition and total charge safety timers.
// Assumes a single clock; tick divider lives here.
`timescale 1ns/1ps
`default_nettype none
module charge_timer
  import charger_pkg::*;
#(
  parameter longint unsigned TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Control side
  timer_if.timer    tmr
);
  logic [32:0] div_count;  // Full-rate tick count exceeds 32 bits
  logic        tick;
  logic [9:0]  pre_count;
  logic [9:0]  tot_count;
  logic [9:0]  pre_limit;
  logic [9:0]  tot_limit;
  logic        disabled;

  // Limits per selection; code 11 never expires
  assign disabled  = (tmr.select == TMO_OFF);                           // [RQ1]
  assign pre_limit = (tmr.select == TMO_1P43H) ? PRE_TICKS_1P43H :
                     (tmr.select == TMO_2H)    ? PRE_TICKS_2H : PRE_TICKS_1H;  // [RQ1]
  assign tot_limit = (tmr.select == TMO_1P43H) ? TOT_TICKS_4P3H :
                     (tmr.select == TMO_2H)    ? TOT_TICKS_6H : TOT_TICKS_3H;  // [RQ1]
  assign tick      = (div_count == 33'(TICK_DIV - 64'h1));
  assign tmr.pre_done = !disabled && (pre_count >= pre_limit);
  assign tmr.tot_done = !disabled && (tot_count >= tot_limit);

  // Slow tick divider, restarted with the timers
  always_ff @(posedge clk_in) begin
    if (rst_in || tmr.clear || tick) begin
      div_count <= 33'h0;
    end else begin
      div_count <= div_count + 33'h1;
    end
  end

  // Counters saturate so a done flag never wraps away
  always_ff @(posedge clk_in) begin
    if (rst_in || tmr.clear) begin                                      // [RQ18]
      pre_count <= 10'h0;
      tot_count <= 10'h0;
    end else if (tick) begin                                            // [RQ18]
      if (tmr.run_pre && pre_count != 10'h3FF) pre_count <= pre_count + 10'h1;
      if (tmr.run_tot && tot_count != 10'h3FF) tot_count <= tot_count + 10'h1;
    end
  end
endmodule : charge_timer
`default_nettype wire

//--- src/charger_fsm.sv
// Charger control state machine for a single lithium cell.
// Assumes comparator inputs are clean, synchronous levels from the analog front end.
`timescale 1ns/1ps
`default_nettype none
// Contract
// [RQ1] Timeout select sets both timers; 11 disables
// [RQ2] New cycle starts in precondition at tenth current
// [RQ3] Precondition threshold reached moves to fast charge
// [RQ4] Precondition timeout flags fault state
// [RQ5] Fast charge commands constant current at setting
// [RQ6] Termination voltage reached moves to top-off
// [RQ7] Total timeout during fast charge goes to sleep
// [RQ8] Top-off constant voltage; end-of-charge goes sleep
// [RQ9] Sleep high impedance; restart below restart threshold
// [RQ10] Suspend bit set suspends; clearing restarts precondition
// [RQ11] Fault exits only to suspend on listed events
// [RQ12] No battery with input powers system at 1000mA
// [RQ13] No battery keeps timers disabled, thermal active; this design has no thermal input or regulation
// [RQ14] Host stops battery-less powering via pin or bit
// [RQ15] Battery reconnect resets timers, enters precondition
// [RQ16] Input loss forces suspend and isolates battery
// [RQ17] Enable pin high disables charger always
// [RQ18] Timers count a slow tick, cleared on reset
// [RQ19] State and sticky fault readable by software
module charger_fsm
  import charger_pkg::*;
#(
  parameter longint unsigned TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Software and pin controls
  input  wire logic [1:0] timeout_select_in,
  input  wire logic [3:0] fast_current_setting_in,
  input  wire logic       suspend_charge_in,
  input  wire logic       charge_enable_n_in,
  input  wire logic       fault_clear_in,
  // Comparator results
  input  wire logic       supply_ok_in,        // Input above 4 V lockout level
  input  wire logic       supply_above_bat_in, // Input above battery voltage
  input  wire logic       battery_present_in,
  input  wire logic       above_precond_in,    // Battery above 2.9 V
  input  wire logic       at_termination_in,   // Battery at termination setting
  input  wire logic       below_restart_in,    // Battery 200 mV under termination
  input  wire logic       below_eoc_in,        // Current under tenth of setting
  // Regulation commands
  output logic            charger_on_out,
  output logic            cc_mode_out,
  output logic            cv_mode_out,
  output logic            precond_current_out, // Tenth of setting
  output logic [3:0]      current_code_out,
  output logic            battery_isolate_out,
  // Status
  output logic [2:0]      state_out,
  output logic            timeout_fault_out
);
  timer_if tmr ();
  charge_state_t state;
  charge_state_t next_state;
  logic          suspend_cause;
  logic          suspend_prev;
  logic          suspend_fall;
  logic          host_off;
  logic          supply_lost;
  // One-hot view of the coming state, shared by all output decodes
  logic          to_suspend;
  logic          to_precond;
  logic          to_fast;
  logic          to_topoff;
  logic          to_sleep;
  logic          to_fault;
  logic          to_nobat;
  // Coming values of the registered outputs
  logic          next_on;
  logic          next_cc;
  logic          next_cv;
  logic          next_pre;
  logic          next_iso;
  logic [3:0]    next_code;
  logic          next_fault;

  // Safety timers; frozen outside precondition and fast charge
  charge_timer #(.TICK_DIV(TICK_DIV)) u_timer (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .tmr    (tmr)
  );

  // Host request and supply loss, each enough to force the charger off
  assign host_off      = suspend_charge_in || charge_enable_n_in;      // [RQ10] [RQ17] [RQ14]
  assign supply_lost   = !supply_ok_in || !supply_above_bat_in;        // [RQ16]
  assign suspend_cause = host_off || supply_lost;                      // [RQ11]
  // Falling edge of the suspend bit
  assign suspend_fall  = suspend_prev && !suspend_charge_in;

  // Timer control: counting only in precondition and fast charge
  assign tmr.select  = timeout_select_in;                               // [RQ1]
  assign tmr.run_pre = (state == ST_PRECOND);
  assign tmr.run_tot = (state == ST_PRECOND) || (state == ST_FAST);     // [RQ13]
  // Restart timers when entering precondition from elsewhere
  assign tmr.clear   = to_precond && (state != ST_PRECOND);             // [RQ10] [RQ15]

  // Next state; fault leaves only toward suspend
  always_comb begin
    next_state = state;
    case (state)
      ST_SUSPEND: begin
        if (!suspend_cause)
          next_state = battery_present_in ? ST_PRECOND : ST_NOBAT;      // [RQ2] [RQ12]
      end
      // Tenth current until the cell passes the threshold
      ST_PRECOND: begin
        if (suspend_cause)               next_state = ST_SUSPEND;
        else if (!battery_present_in)    next_state = ST_NOBAT;
        else if (above_precond_in)       next_state = ST_FAST;          // [RQ3]
        else if (tmr.pre_done)           next_state = ST_FAULT;         // [RQ4]
      end
      // Full current until the termination voltage
      ST_FAST: begin
        if (suspend_cause)               next_state = ST_SUSPEND;
        else if (!battery_present_in)    next_state = ST_NOBAT;
        else if (at_termination_in)      next_state = ST_TOPOFF;        // [RQ6]
        else if (tmr.tot_done)           next_state = ST_SLEEP;         // [RQ7]
      end
      // Constant voltage until the current tails off
      ST_TOPOFF: begin
        if (suspend_cause)               next_state = ST_SUSPEND;
        else if (!battery_present_in)    next_state = ST_NOBAT;
        else if (below_eoc_in)           next_state = ST_SLEEP;         // [RQ8]
      end
      // Switch open; a restart skips precondition
      ST_SLEEP: begin
        if (suspend_cause)               next_state = ST_SUSPEND;
        else if (!battery_present_in)    next_state = ST_NOBAT;
        else if (below_restart_in)       next_state = ST_FAST;          // [RQ9]
      end
      // A damaged cell stays here until a host or supply event or battery removal
      ST_FAULT: begin
        if (suspend_cause || !battery_present_in) next_state = ST_SUSPEND; // [RQ11]
      end
      // No cell: power the system with the timers held
      ST_NOBAT: begin
        if (suspend_cause)               next_state = ST_SUSPEND;       // [RQ14]
        else if (battery_present_in)     next_state = ST_PRECOND;       // [RQ15]
      end
      // Unused code 111 falls back to suspend
      default: next_state = ST_SUSPEND;
    endcase
    // Clearing the suspend bit restarts with precondition when no other cause is present and a battery is present
    if (suspend_fall && !suspend_cause && battery_present_in)
      next_state = ST_PRECOND;                                          // [RQ10]
  end

  // Coming-state decode; outputs are registered from these so they
  // always agree with state_out in the same cycle
  assign to_suspend = (next_state == ST_SUSPEND);
  assign to_precond = (next_state == ST_PRECOND);
  assign to_fast    = (next_state == ST_FAST);
  assign to_topoff  = (next_state == ST_TOPOFF);
  assign to_sleep   = (next_state == ST_SLEEP);
  assign to_fault   = (next_state == ST_FAULT);
  assign to_nobat   = (next_state == ST_NOBAT);

  // Regulation commands of the coming state
  assign next_on    = to_precond || to_fast || to_topoff || to_nobat;   // [RQ17]
  assign next_cc    = to_precond || to_fast;                            // [RQ5]
  assign next_cv    = to_topoff || to_nobat;                            // [RQ8] [RQ12]
  assign next_pre   = to_precond;                                       // [RQ2]
  // Battery-less mode ignores the programmed current and uses the full limit
  assign next_code  = to_nobat ? NOBAT_CURRENT_CODE : fast_current_setting_in; // [RQ12]
  // Sleep, suspend and fault keep the switch open to spare the cell
  assign next_iso   = to_sleep || to_suspend || to_fault;               // [RQ9] [RQ16]
  // Sticky fault; a fresh fault outranks a clear in the same cycle
  assign next_fault = to_fault || (timeout_fault_out && !fault_clear_in); // [RQ4] [RQ19]

  // State register; start suspended until conditions settle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= ST_SUSPEND;
    end else begin
      state <= next_state;
    end
  end

  // Last suspend bit, for spotting its release
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      suspend_prev <= 1'b0;
    end else begin
      suspend_prev <= suspend_charge_in;
    end
  end

  // Regulation commands; reset leaves the switch open until a state is chosen
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      charger_on_out      <= 1'b0;
      cc_mode_out         <= 1'b0;
      cv_mode_out         <= 1'b0;
      precond_current_out <= 1'b0;
      current_code_out    <= 4'h0;
      battery_isolate_out <= 1'b1;
    end else begin
      charger_on_out      <= next_on;
      cc_mode_out         <= next_cc;
      cv_mode_out         <= next_cv;
      precond_current_out <= next_pre;
      current_code_out    <= next_code;
      battery_isolate_out <= next_iso;
    end
  end

  // Status for software
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_out         <= 3'h0;
      timeout_fault_out <= 1'b0;
    end else begin
      state_out         <= next_state;                                  // [RQ19]
      timeout_fault_out <= next_fault;                                  // [RQ19]
    end
  end
endmodule : charger_fsm
`default_nettype wire

//--- test/charger_fsm_checker.sv
// Port-level checks of the charger state machine.
// Bound onto charger_fsm; one clock, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module charger_fsm_checker
  import charger_pkg::*;
(
  // Clock, reset and host controls
  input wire logic       clk_in, rst_in, suspend_charge_in, charge_enable_n_in,
  // Comparator results
  input wire logic       supply_ok_in, supply_above_bat_in, battery_present_in,
  input wire logic       above_precond_in, at_termination_in, below_restart_in, below_eoc_in,
  // Outputs under watch
  input wire logic       cc_mode_out, precond_current_out, battery_isolate_out,
  input wire logic [3:0] current_code_out,
  input wire logic [2:0] state_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Any suspend cause outranks every state, so progress needs none of them
  wire logic cause = suspend_charge_in | charge_enable_n_in | ~supply_ok_in | ~supply_above_bat_in;
  wire logic run   = ~cause & battery_present_in;
  sequence s_go(logic [2:0] s, logic c);
    run && state_out == s && c;
  endsequence
  AST_CAUSE: assert property (cause |=> state_out == ST_SUSPEND && battery_isolate_out)
    else $error("suspend cause ignored");
  AST_PRE: assert property (s_go(ST_PRECOND, above_precond_in) |=> state_out == ST_FAST)
    else $error("no fast charge after threshold");
  AST_FAST: assert property (s_go(ST_FAST, at_termination_in) |=> state_out == ST_TOPOFF)
    else $error("no top-off at termination");
  AST_EOC: assert property (s_go(ST_TOPOFF, below_eoc_in) |=> state_out == ST_SLEEP)
    else $error("no sleep at end of charge");
  AST_RESTART: assert property (s_go(ST_SLEEP, below_restart_in) |=> state_out == ST_FAST)
    else $error("no restart from sleep");
  AST_RELEASE: assert property (s_go(ST_SUSPEND, 1'b1) |=> state_out == ST_PRECOND)
    else $error("release did not precondition");
  AST_FAULT: assert property (s_go(ST_FAULT, 1'b1) |=> state_out == ST_FAULT)
    else $error("fault left without cause");
  AST_NOBAT: assert property (!cause && !battery_present_in && state_out != ST_FAULT |=>
    state_out == ST_NOBAT && current_code_out == NOBAT_CURRENT_CODE) else $error("no bat mode");
  AST_PRECUR: assert property (state_out == ST_PRECOND |-> precond_current_out && cc_mode_out)
    else $error("precondition current wrong");
endmodule : charger_fsm_checker
bind charger_fsm charger_fsm_checker i_charger_fsm_checker (.clk_in, .rst_in, .suspend_charge_in,
  .charge_enable_n_in, .supply_ok_in, .supply_above_bat_in, .battery_present_in,
  .above_precond_in, .at_termination_in, .below_restart_in, .below_eoc_in, .cc_mode_out,
  .precond_current_out, .battery_isolate_out, .current_code_out, .state_out);
`default_nettype wire

//--- test/cell_model.sv
// Behavioural cell: voltage and current as seen by the comparators.
// Mode 0 charges, 1 is a dead cell at 2.5 V, 2 freezes the voltage while the charger is on.
`timescale 1ns/1ps
`default_nettype none
module cell_model (
  // Charger commands
  input  wire logic       clk_in, on_in, pre_in, cv_in,
  input  wire logic [1:0] mode_in,
  // Comparator results
  output logic            above_pre_out, at_term_out, below_rst_out, below_eoc_out
);
  int mv = 2500;
  int ma = 100;
  // Cell moves only off the sampling edge; leaks while the charger is off
  always @(negedge clk_in) begin
    if (mode_in == 2'h1) mv <= 2500;
    else if (on_in && mode_in == 2'h0) mv <= (mv > 4170) ? 4200 : mv + (pre_in ? 8 : 25);
    else if (!on_in && mv > 2500) mv <= mv - 3;
    ma <= cv_in ? ma - 2 : 100;
  end
  assign above_pre_out = mv >= 2900;
  assign at_term_out   = mv >= 4200;
  assign below_rst_out = mv < 4000; // 200 mV under a 4.2 V setting
  assign below_eoc_out = ma < 10;   // Tenth of the fast current
endmodule : cell_model
`default_nettype wire

//--- test/battery_charge_state_machine_tb_top.sv
// Self-checking bench: charger state machine against a behavioural cell.
// Tick divider of 2 keeps each safety timeout to some hundreds of cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module battery_charge_state_machine_tb_top;
  import charger_pkg::*;
  localparam int TD = 2;
  localparam int PRE[3] = '{100, 143, 200};
  localparam int TOT[3] = '{300, 430, 600};
  logic        clk_in = 1'b0, rst_in = 1'b1, susp = 1'b0, en_n = 1'b0, fclr = 1'b0;
  logic        ok = 1'b1, abv = 1'b1, bat = 1'b1, ap, at, br, be, on, cc, cv, pc, iso, flt;
  logic [1:0]  sel = TMO_1H, mode = 2'h0;
  logic [2:0]  st;
  logic [3:0]  fast_current_setting = 4'h4, code;
  logic [31:0] seed = 32'h000010B0, r;
  int          failures = 0, checks = 0, n, m;
  // Free-running clock
  always #4 clk_in = ~clk_in;
  charger_fsm #(.TICK_DIV(TD)) i_charger_fsm (.clk_in, .rst_in, .timeout_select_in(sel),
    .fast_current_setting_in(fast_current_setting), .suspend_charge_in(susp), .charge_enable_n_in(en_n),
    .fault_clear_in(fclr), .supply_ok_in(ok), .supply_above_bat_in(abv), .battery_present_in(bat),
    .above_precond_in(ap), .at_termination_in(at), .below_restart_in(br), .below_eoc_in(be),
    .charger_on_out(on), .cc_mode_out(cc), .cv_mode_out(cv), .precond_current_out(pc),
    .current_code_out(code), .battery_isolate_out(iso), .state_out(st), .timeout_fault_out(flt));
  cell_model i_cell_model (.clk_in, .on_in(on), .pre_in(pc), .cv_in(cv), .mode_in(mode),
    .above_pre_out(ap), .at_term_out(at), .below_rst_out(br), .below_eoc_out(be));
  // Xorshift source, fixed seed
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // Expected timeout length in cycles for a count of ticks
  function automatic int timeout_cycles(input int ticks);
    return ticks * TD;
  endfunction : timeout_cycles
  // Bounded wait for a state; cycles spent are left in n
  task automatic wait_st(input logic [2:0] s, input int lim);
    n = 0;
    while (st !== s && n < lim) begin
      @(negedge clk_in);
      n++;
    end
    // A state that never came ends the run as a mismatch
    if (st !== s) begin
      `CHK(st, s)
      print_verdict();
    end
  endtask : wait_st
  initial begin
    repeat (4) @(negedge clk_in);
    `CHK({st, iso}, {ST_SUSPEND, 1'b1})
    rst_in = 1'b0;
    wait_st(ST_PRECOND, 4);
    `CHK({on, cc, pc, iso}, 4'hE)
    wait_st(ST_FAST, 80);
    `CHK({pc, cc, code}, {2'b01, fast_current_setting})
    wait_st(ST_TOPOFF, 80);
    `CHK(cv, 1'b1)
    wait_st(ST_SLEEP, 80);
    `CHK(iso, 1'b1)
    wait_st(ST_FAST, 100);
    // Host applies one random suspend cause at a random point of the cycle
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      fast_current_setting = r[3:0];
      {susp, en_n, ok, abv} = (4'b1000 >> r[5:4]) ^ 4'b0011;
      @(negedge clk_in);
      `CHK({st, iso}, {ST_SUSPEND, 1'b1})
      {susp, en_n, ok, abv} = 4'b0011;
      @(negedge clk_in);
      `CHK({st, code}, {ST_PRECOND, fast_current_setting})
      repeat (r[15:9]) @(negedge clk_in);
    end
    // Battery-less powering, stopped by pin, then held in suspend by bit
    bat = 1'b0;
    @(negedge clk_in);
    `CHK({st, code, cv}, {ST_NOBAT, NOBAT_CURRENT_CODE, 1'b1})
    repeat (700) @(negedge clk_in);
    `CHK({st, flt}, {ST_NOBAT, 1'b0})
    en_n = 1'b1;
    @(negedge clk_in);
    `CHK(st, ST_SUSPEND)
    {en_n, susp} = 2'b01;
    @(negedge clk_in);
    `CHK(st, ST_SUSPEND)
    susp = 1'b0;
    repeat (2) @(negedge clk_in);
    bat = 1'b1;
    @(negedge clk_in);
    `CHK(st, ST_PRECOND)
    // Timeout codes 0 to 2: dead cell faults, slow cell times out in fast charge
    for (int s = 0; s < 3; s++) begin
      sel = s[1:0];
      {susp, mode} = 3'b101;
      @(negedge clk_in);
      susp = 1'b0;
      @(negedge clk_in);
      wait_st(ST_FAULT, timeout_cycles(PRE[s]) + 4);
      `CHK({n > timeout_cycles(PRE[s]) - 4, flt}, 2'b11)
      repeat (20) @(negedge clk_in);
      abv = 1'b0;
      @(negedge clk_in);
      `CHK({st, flt}, {ST_SUSPEND, 1'b1})
      {abv, fclr, mode} = 4'b1100;
      @(negedge clk_in);
      fclr = 1'b0;
      `CHK(flt, 1'b0)
      wait_st(ST_FAST, 80);
      m = n;
      mode = 2'h2;
      wait_st(ST_SLEEP, timeout_cycles(TOT[s]) + 4 - m);
      `CHK(m + n > timeout_cycles(TOT[s]) - 4, 1'b1)
    end
    // Reset in mid-run: back to suspend with the switch open and no fault
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    `CHK({st, on, cc, iso, flt}, {ST_SUSPEND, 4'b0010})
    rst_in = 1'b0;
    // Timers disabled: a dead cell stays in precondition
    sel = TMO_OFF;
    {susp, mode} = 3'b101;
    @(negedge clk_in);
    susp = 1'b0;
    repeat (800) @(negedge clk_in);
    `CHK(st, ST_PRECOND)
    print_verdict();
  end
endmodule : battery_charge_state_machine_tb_top
`default_nettype wire
